//--- design/stap_pkg.sv
/*
 constants for the scan test access port: tap states, instruction codes,
 reset values and pin positions of the pull-up controls.
 assumes one sampling clock much faster than the test clock.
*/
// What this block and its controller do
// RL1: test data captured on rising test clock
// RL2: test data output changes on falling edges
// RL3: output floats except while shifting
// RL4: mode select and data sampled rising edge
// RL5: test reset high gives scan control
// RL6: test reset low means functional, ignore
// RL7: controller must pulse test reset low once
// RL8: controller supplies free-running 50% clock; the emulator model toggles tck only inside tick
// RL9: event b pin direction set by emulation
// RL10: pull-up per pin can be inhibited
// RL11: event a latched at reset rise routes
// RL12: standard sixteen-state tap machine
package stap_pkg;
   typedef enum logic [3:0] {
      STAP_EXIT2_DR = 4'h0,
      STAP_EXIT1_DR = 4'h1,
      STAP_SHIFT_DR = 4'h2,
      STAP_PAUSE_DR = 4'h3,
      STAP_SEL_IR = 4'h4,
      STAP_UPDATE_DR = 4'h5,
      STAP_CAPTURE_DR = 4'h6,
      STAP_SEL_DR = 4'h7,
      STAP_EXIT2_IR = 4'h8,
      STAP_EXIT1_IR = 4'h9,
      STAP_SHIFT_IR = 4'ha,
      STAP_PAUSE_IR = 4'hb,
      STAP_IDLE = 4'hc,
      STAP_UPDATE_IR = 4'hd,
      STAP_CAPTURE_IR = 4'he,
      STAP_RESET = 4'hf
   } stap_state_t;
   localparam int STAP_IR_W = 4;
   localparam int STAP_DR_W = 8;
   localparam logic [STAP_IR_W-1:0] STAP_IR_BYPASS = 4'hf;
   localparam logic [STAP_IR_W-1:0] STAP_IR_USER = 4'h1;
   localparam logic [STAP_IR_W-1:0] STAP_IR_CAPTURE = 4'h1;
   localparam logic [STAP_IR_W-1:0] STAP_IR_RESET = 4'hf;
   // synchroniser slots
   localparam int STAP_SYN_TCK = 0;
   localparam int STAP_SYN_TMS = 1;
   localparam int STAP_SYN_TDI = 2;
   localparam int STAP_SYN_TRST = 3;
   localparam int STAP_SYN_EVA = 4;
   localparam int STAP_SYN_EVB = 5;
   localparam int STAP_SYN_N = 6;
   // pull-up control bit positions
   localparam int STAP_PU_TCK = 0;
   localparam int STAP_PU_TMS = 1;
   localparam int STAP_PU_TDI = 2;
   localparam int STAP_PU_EVA = 3;
   localparam int STAP_PU_EVB = 4;
   localparam int STAP_PU_N = 5;
   localparam logic [STAP_PU_N-1:0] STAP_PU_RESET = 5'h1f;
   localparam logic STAP_ROUTE_RESET = 1'b0;
endpackage : stap_pkg

//--- design/stap_top.sv
/*
 scan test access port: samples the test pins on sys_clk_i, runs the tap
 machine on test clock edges, drives the test data output on falling edges.
 assumes the test clock is at most an eighth of sys_clk_i.
*/
`timescale 1ns/1ns
module stap_top
   import stap_pkg::*;
#(
   parameter int IR_W = STAP_IR_W,
   parameter int DR_W = STAP_DR_W
)
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // scan pins
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   input wire logic test_reset_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   // emulator event pins
   input wire logic emulator_event_a_tap_select_i,
   input wire logic emulator_event_b_i,
   output logic emulator_event_b_o,
   output logic emulator_event_b_oe_o,
   // emulation logic side of event b
   input wire logic event_b_drive_i,
   input wire logic event_b_value_i,
   output logic event_b_seen_o,
   // pull-up configuration
   input wire logic [STAP_PU_N-1:0] pull_inhibit_config_i,
   output logic [STAP_PU_N-1:0] internal_pull_up_o,
   // mode and routing
   output logic test_mode_o,
   output logic tap_route_o,
   output logic [IR_W-1:0] instr_o,
   // user data register
   input wire logic [DR_W-1:0] dr_capture_i,
   output logic [DR_W-1:0] dr_update_o,
   output logic dr_update_stb_o
);
   logic [STAP_SYN_N-1:0] syn1;
   logic [STAP_SYN_N-1:0] syn2;
   logic tck_d;
   logic trst_d;
   stap_state_t state;
   stap_state_t next_state;
   logic [IR_W-1:0] ir_sh;
   logic [DR_W-1:0] dr_sh;
   logic bypass;

   wire [STAP_SYN_N-1:0] syn_in = {emulator_event_b_i, emulator_event_a_tap_select_i,
                                   test_reset_i, tdi_i, tms_i, tck_i};
   // two-flop synchronisers, one per sampled pin
   genvar gi;
   generate
      for (gi = 0; gi < STAP_SYN_N; gi++)
      begin : g_syn
         always_ff @(posedge sys_clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               syn1[gi] <= 1'b0;
               syn2[gi] <= 1'b0;
            end
            else
            begin
               syn1[gi] <= syn_in[gi];
               syn2[gi] <= syn1[gi];
            end
         end
      end
   endgenerate

   wire tck_s = syn2[STAP_SYN_TCK];
   wire tms_s = syn2[STAP_SYN_TMS];
   wire tdi_s = syn2[STAP_SYN_TDI];
   wire trst_s = syn2[STAP_SYN_TRST];
   wire eva_s = syn2[STAP_SYN_EVA];
   wire evb_s = syn2[STAP_SYN_EVB];
   // edges only count while test reset is high, so tck, tms and tdi are ignored otherwise
   wire tck_rise = trst_s && tck_s && !tck_d;
   wire tck_fall = trst_s && !tck_s && tck_d;
   wire trst_rise = trst_s && !trst_d;
   wire sel_user = (instr_o == STAP_IR_USER);
   wire in_shift = (state == STAP_SHIFT_IR) || (state == STAP_SHIFT_DR);
   wire dr_out = sel_user ? dr_sh[0] : bypass;
   wire next_tdo = (state == STAP_SHIFT_IR) ? ir_sh[0] : dr_out;

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         tck_d <= 1'b0;
         trst_d <= 1'b0;
      end
      else
      begin
         tck_d <= tck_s;
         trst_d <= trst_s;
      end
   end

   // tap next state from mode select
   always_comb
   begin
      next_state = state;
      unique case (state)
         STAP_RESET: next_state = tms_s ? STAP_RESET : STAP_IDLE;
         STAP_IDLE: next_state = tms_s ? STAP_SEL_DR : STAP_IDLE;
         STAP_SEL_DR: next_state = tms_s ? STAP_SEL_IR : STAP_CAPTURE_DR;
         STAP_CAPTURE_DR: next_state = tms_s ? STAP_EXIT1_DR : STAP_SHIFT_DR;
         STAP_SHIFT_DR: next_state = tms_s ? STAP_EXIT1_DR : STAP_SHIFT_DR;
         STAP_EXIT1_DR: next_state = tms_s ? STAP_UPDATE_DR : STAP_PAUSE_DR;
         STAP_PAUSE_DR: next_state = tms_s ? STAP_EXIT2_DR : STAP_PAUSE_DR;
         STAP_EXIT2_DR: next_state = tms_s ? STAP_UPDATE_DR : STAP_SHIFT_DR;
         STAP_UPDATE_DR: next_state = tms_s ? STAP_SEL_DR : STAP_IDLE;
         STAP_SEL_IR: next_state = tms_s ? STAP_RESET : STAP_CAPTURE_IR;
         STAP_CAPTURE_IR: next_state = tms_s ? STAP_EXIT1_IR : STAP_SHIFT_IR;
         STAP_SHIFT_IR: next_state = tms_s ? STAP_EXIT1_IR : STAP_SHIFT_IR;
         STAP_EXIT1_IR: next_state = tms_s ? STAP_UPDATE_IR : STAP_PAUSE_IR;
         STAP_PAUSE_IR: next_state = tms_s ? STAP_EXIT2_IR : STAP_PAUSE_IR;
         STAP_EXIT2_IR: next_state = tms_s ? STAP_UPDATE_IR : STAP_SHIFT_IR;
         STAP_UPDATE_IR: next_state = tms_s ? STAP_SEL_DR : STAP_IDLE;
      endcase
   end

   // RL12 tap machine, RL6 held in reset
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state <= STAP_RESET;
      else if (!trst_s)
         state <= STAP_RESET;
      else if (tck_rise)
         state <= next_state;
   end

   // RL1 RL4 capture and shift on rising edge
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ir_sh <= STAP_IR_RESET;
         dr_sh <= '0;
         bypass <= 1'b0;
      end
      else if (tck_rise)
      begin
         if (state == STAP_CAPTURE_IR)
            ir_sh <= STAP_IR_CAPTURE;
         else if (state == STAP_SHIFT_IR)
            ir_sh <= {tdi_s, ir_sh[IR_W-1:1]};
         if (state == STAP_CAPTURE_DR)
         begin
            dr_sh <= dr_capture_i;
            bypass <= 1'b0;
         end
         else if (state == STAP_SHIFT_DR)
         begin
            if (sel_user)
               dr_sh <= {tdi_s, dr_sh[DR_W-1:1]};
            else
               bypass <= tdi_s;
         end
      end
   end

   // instruction and user register updates
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         instr_o <= STAP_IR_RESET;
         dr_update_o <= '0;
         dr_update_stb_o <= 1'b0;
      end
      else
      begin
         dr_update_stb_o <= tck_rise && (state == STAP_UPDATE_DR) && sel_user;
         if (state == STAP_RESET)
            instr_o <= STAP_IR_RESET;
         else if (tck_rise && (state == STAP_UPDATE_IR))
            instr_o <= ir_sh;
         if (tck_rise && (state == STAP_UPDATE_DR) && sel_user)
            dr_update_o <= dr_sh;
      end
   end

   // RL2 RL3 output driven on falling edge, only while shifting
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         tdo_o <= 1'b0;
         tdo_oe_o <= 1'b0;
      end
      else if (!trst_s)
         tdo_oe_o <= 1'b0;
      else if (tck_fall)
      begin
         tdo_oe_o <= in_shift;
         if (in_shift)
            tdo_o <= next_tdo;
      end
   end

   // RL5 RL11 mode follows test reset, route latched at reset release
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         test_mode_o <= 1'b0;
         tap_route_o <= STAP_ROUTE_RESET;
      end
      else
      begin
         test_mode_o <= trst_s;
         if (trst_rise)
            tap_route_o <= eva_s;
      end
   end

   // RL9 RL10 event b direction and pull-up control
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         emulator_event_b_o <= 1'b0;
         emulator_event_b_oe_o <= 1'b0;
         event_b_seen_o <= 1'b0;
         internal_pull_up_o <= STAP_PU_RESET;
      end
      else
      begin
         emulator_event_b_o <= event_b_value_i;
         emulator_event_b_oe_o <= event_b_drive_i && trst_s;
         event_b_seen_o <= evb_s && !emulator_event_b_oe_o;
         internal_pull_up_o <= ~pull_inhibit_config_i;
      end
   end

   sequence s_fall;
      tck_fall;
   endsequence

   sequence s_shift_edge;
      tck_fall && in_shift;
   endsequence

   // RL2 output timing
   tdo_change_edge_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RL2
      $changed(tdo_o) |-> $past(tck_fall)) else $error("tdo changed off a falling edge");
   // RL3 enable follows shift
   tdo_float_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RL3
      s_shift_edge |=> tdo_oe_o) else $error("tdo not enabled in shift");
   tdo_off_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RL3
      s_fall ##0 !in_shift |=> !tdo_oe_o) else $error("tdo enabled outside shift");
   // RL6 functional mode
   func_mode_reset_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RL6
      !trst_s |=> (state == STAP_RESET) && !tdo_oe_o) else $error("pins not ignored");
   // RL5 test control
   test_mode_flag_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RL5
      trst_s |=> test_mode_o) else $error("test mode not taken");
   // RL1 bypass capture
   bypass_capture_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RL1
      tck_rise && (state == STAP_SHIFT_DR) && !sel_user |=> bypass == $past(tdi_s))
      else $error("bypass missed tdi");
   // RL4 instruction shift
   ir_shift_in_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RL4
      tck_rise && (state == STAP_SHIFT_IR) |=> ir_sh[IR_W-1] == $past(tdi_s))
      else $error("ir missed tdi");
   // RL11 route latch
   route_latch_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RL11
      trst_rise |=> tap_route_o == $past(eva_s)) else $error("route not latched");
   // RL9 event b direction
   event_b_dir_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RL9
      emulator_event_b_oe_o |-> $past(event_b_drive_i)) else $error("event b driven unasked");
   // RL10 pull-up control
   pull_up_cfg_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RL10
      ##1 internal_pull_up_o == ~$past(pull_inhibit_config_i)) else $error("pull-up wrong");
   // RL12 state step
   fsm_leave_reset_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RL12
      tck_rise && (state == STAP_RESET) && !tms_s |=> state == STAP_IDLE)
      else $error("tap did not leave reset");
endmodule : stap_top

//--- verification/stap_emu_model.sv
/*
 emulator model for the scan test access port: makes test clock, mode
 select, data in, test reset, event a and its side of event b.
 assumes the bench resolves tdo and event b wires with pull-ups.
*/
`timescale 1ns/1ns
module stap_emu_model
(
   // bench clock
   input wire logic sys_clk_i,
   // scan pins
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   output logic test_reset_o,
   input wire logic tdo_wire_i,
   input wire logic tdo_oe_i,
   // event pins
   output logic event_a_o,
   output logic event_b_drive_o,
   output logic event_b_value_o
);
   logic tdo_seen = 1'b1;
   int oe_count = 0;
   initial
   begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
      test_reset_o = 1'b0;
      event_a_o = 1'b1;
      event_b_drive_o = 1'b0;
      event_b_value_o = 1'b1;
   end
   task tick(input logic tms, input logic tdi);
      tms_o <= tms;
      tdi_o <= tdi;
      repeat (4) @(negedge sys_clk_i);
      tdo_seen = tdo_wire_i;
      oe_count += int'(tdo_oe_i);
      tck_o <= 1'b1;
      repeat (4) @(negedge sys_clk_i);
      tck_o <= 1'b0;
   endtask : tick
   task scan(input logic ir, input logic [7:0] din, input int n, output logic [7:0] dout);
      dout = 8'h00;
      tick(1'b1, 1'b1);
      if (ir)
         tick(1'b1, 1'b1);
      tick(1'b0, 1'b1);
      tick(1'b0, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         tick(i == n - 1, din[i]);
         dout[i] = tdo_seen;
      end
      tick(1'b1, 1'b1);
      tick(1'b0, 1'b1);
   endtask : scan
   // low pulse, route on event a
   task trst_pulse(input logic route);
      test_reset_o <= 1'b0;
      event_a_o <= route;
      repeat (8) @(negedge sys_clk_i);
      test_reset_o <= 1'b1;
      repeat (8) @(negedge sys_clk_i);
      event_a_o <= 1'b1;
      tick(1'b0, 1'b1);
   endtask : trst_pulse
   task ev_b(input logic drv, input logic val);
      event_b_drive_o <= drv;
      event_b_value_o <= val;
   endtask : ev_b
endmodule : stap_emu_model

//--- verification/testbench.sv
/*
 self-checking bench for the scan test access port, emulator model on
 the pins. assumes pull-ups on the tdo and event b wires.
*/
`timescale 1ns/1ns
module testbench
   import stap_pkg::*;
;
   logic sys_clk_i = 1'b0;
   logic nrst = 1'b0;
   logic tck, tms, tdi, trst, tdo, tdo_oe, ev_a, ev_b_pin, ev_b_oe, ev_b_seen;
   logic emu_drv, emu_val, ev_b_drive = 1'b0, ev_b_value = 1'b0;
   logic test_mode, route, dr_stb;
   logic [STAP_PU_N-1:0] pic = 5'h00;
   logic [STAP_PU_N-1:0] pu;
   logic [3:0] instr;
   logic [7:0] dr_cap = 8'h00;
   logic [7:0] dr_upd;
   logic [7:0] d;
   wire tdo_wire = tdo_oe ? tdo : 1'b1;
   wire ev_b_wire = ev_b_oe ? ev_b_pin : (emu_drv ? emu_val : 1'b1);
   int err_total = 0;
   int samples_checked = 0;
   int stb_count = 0;
   always #4 sys_clk_i = ~sys_clk_i;
   always @(negedge sys_clk_i)
      if (dr_stb === 1'b1)
         stb_count++;
   stap_top u_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst), .tck_i(tck), .tms_i(tms),
      .tdi_i(tdi), .test_reset_i(trst), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
      .emulator_event_a_tap_select_i(ev_a), .emulator_event_b_i(ev_b_wire),
      .emulator_event_b_o(ev_b_pin), .emulator_event_b_oe_o(ev_b_oe),
      .event_b_drive_i(ev_b_drive), .event_b_value_i(ev_b_value),
      .event_b_seen_o(ev_b_seen), .pull_inhibit_config_i(pic),
      .internal_pull_up_o(pu), .test_mode_o(test_mode), .tap_route_o(route),
      .instr_o(instr), .dr_capture_i(dr_cap), .dr_update_o(dr_upd),
      .dr_update_stb_o(dr_stb));
   stap_emu_model u_emu (.sys_clk_i(sys_clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
      .test_reset_o(trst), .tdo_wire_i(tdo_wire), .tdo_oe_i(tdo_oe), .event_a_o(ev_a),
      .event_b_drive_o(emu_drv), .event_b_value_o(emu_val));
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task print_verdict;
      if (err_total == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task t_functional;
      ev_b_drive = 1'b1;
      u_emu.scan(1'b1, 8'h05, 4, d);
      chk("oe count", 8'h00, 8'(u_emu.oe_count));
      chk("instr", 8'(STAP_IR_BYPASS), 8'(instr));
      chk("test mode", 8'h00, 8'(test_mode));
      chk("event b oe", 8'h00, 8'(ev_b_oe));
      ev_b_drive = 1'b0;
   endtask : t_functional
   task t_route;
      u_emu.trst_pulse(1'b1);
      chk("route", 8'h01, 8'(route));
      u_emu.trst_pulse(1'b0);
      chk("route", 8'h00, 8'(route));
      chk("test mode", 8'h01, 8'(test_mode));
   endtask : t_route
   task t_ir_scans;
      u_emu.oe_count = 0;
      u_emu.scan(1'b1, 8'h06, 4, d);
      chk("ir out", 8'h01, d);
      chk("instr", 8'h06, 8'(instr));
      u_emu.scan(1'b1, 8'h01, 4, d);
      chk("instr", 8'h01, 8'(instr));
      chk("oe count", 8'h08, 8'(u_emu.oe_count));
   endtask : t_ir_scans
   task automatic t_dr_scans;
      logic [7:0] cap[2] = '{8'ha5, 8'h5a};
      logic [7:0] din[2] = '{8'h3c, 8'hc3};
      for (int k = 0; k < 2; k++)
      begin
         dr_cap = cap[k];
         stb_count = 0;
         u_emu.scan(1'b0, din[k], 8, d);
         chk("dr out", cap[k], d);
         chk("dr update", din[k], dr_upd);
         chk("strobes", 8'h01, 8'(stb_count));
      end
   endtask : t_dr_scans
   task t_bypass;
      u_emu.scan(1'b1, 8'h0f, 4, d);
      stb_count = 0;
      u_emu.scan(1'b0, 8'hb7, 8, d);
      chk("bypass out", 8'h6e, d);
      chk("dr update", 8'hc3, dr_upd);
      chk("strobes", 8'h00, 8'(stb_count));
   endtask : t_bypass
   task t_tap_reset;
      u_emu.scan(1'b1, 8'h01, 4, d);
      repeat (5) u_emu.tick(1'b1, 1'b1);
      chk("instr", 8'(STAP_IR_RESET), 8'(instr));
      u_emu.tick(1'b0, 1'b1);
   endtask : t_tap_reset
   task t_event_b;
      for (int v = 0; v < 2; v++)
      begin
         ev_b_drive = 1'b1;
         ev_b_value = v[0];
         repeat (6) @(negedge sys_clk_i);
         chk("event b wire", 8'(v), 8'(ev_b_wire));
         ev_b_drive = 1'b0;
         u_emu.ev_b(v == 0, 1'b0);
         repeat (6) @(negedge sys_clk_i);
         chk("event b seen", 8'(v), 8'(ev_b_seen));
      end
   endtask : t_event_b
   task t_pullup;
      for (int i = 0; i < STAP_PU_N; i++)
      begin
         pic = 5'(1 << i);
         repeat (2) @(negedge sys_clk_i);
         chk("pull up", {3'h0, ~pic}, 8'(pu));
      end
   endtask : t_pullup
   initial
   begin
      repeat (5) @(negedge sys_clk_i);
      chk("pull up", 8'(STAP_PU_RESET), 8'(pu));
      chk("instr", 8'(STAP_IR_RESET), 8'(instr));
      nrst = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      t_functional();
      t_route();
      t_ir_scans();
      t_dr_scans();
      t_bypass();
      t_tap_reset();
      t_event_b();
      t_pullup();
      print_verdict();
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk_i);
      err_total++;
      print_verdict();
   end
endmodule : testbench
